// >>> common/uirp_pkg.sv
/*
 Types shared by the indirect register port and its core-side requester.
 Assumes the constants header sits beside it on the include path.
*/
`include "uirp_regs.svh"

package uirp_pkg;

    // Request toward the core register file
    typedef struct packed {
        logic       req;
        logic       write;
        logic [5:0] index;
        logic [7:0] wdata;
    } uirp_core_req_type;

    // Answer from the core register file
    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } uirp_core_rsp_type;

    typedef enum logic [1:0] {
        UIRP_IDLE,
        UIRP_READ,
        UIRP_WRITE
    } uirp_state_type;

endpackage

// >>> common/uirp_regs.svh
/*
 Register offsets, field positions and reset values of the
 indirect register port. Assumes inclusion by bare name from the package.
*/
`ifndef UIRP_REGS_SVH
`define UIRP_REGS_SVH

`define UIRP_ADDR_PORT_OFS 8'h96
`define UIRP_DATA_PORT_OFS 8'h97
`define UIRP_ADDR_PORT_RST 8'h00
`define UIRP_DATA_PORT_RST 8'h00
`define UIRP_BUSY_BIT 7
`define UIRP_AUTO_BIT 6
`define UIRP_INDEX_MSB 5
`define UIRP_INDEX_RST 6'h00

`endif

// >>> core/uirp_core_link.sv
/*
 Core-side requester: holds one request to the core register file until the
 core acknowledges it, and registers the read data on acknowledge.
 Assumes the core answers every request within finite time, on i_ref_clk.
*/
`timescale 1ns/10ps
`include "uirp_regs.svh"

module uirp_core_link
    import uirp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [5:0] i_index,
    input wire logic [7:0] i_wdata,
    output uirp_core_req_type o_core_req,
    input wire uirp_core_rsp_type i_core_rsp,
    output logic o_done,
    output logic [7:0] o_rdata
);

    uirp_core_req_type req_reg, req_next;
    logic [7:0] rdata_reg, rdata_next;

    // Launch on start, drop on acknowledge
    always_comb begin
        req_next = req_reg;
        rdata_next = rdata_reg;
        if (req_reg.req && i_core_rsp.ack) begin
            req_next.req = 1'b0;
            if (!req_reg.write) begin
                rdata_next = i_core_rsp.rdata;
            end
        end else if (i_start && !req_reg.req) begin
            req_next = '{req: 1'b1, write: i_write, index: i_index, wdata: i_wdata};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_reg <= '0;
            rdata_reg <= `UIRP_DATA_PORT_RST;
        end else begin
            req_reg <= req_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_core_req = req_reg;
    assign o_done = req_reg.req & i_core_rsp.ack; // Handshake, combinational
    assign o_rdata = rdata_reg;

endmodule // uirp_core_link

// >>> core/uirp_port.sv
/*
 Indirect register port: an address port and a data port on the processor's
 special-function bus, giving access to the core register file by index.
 Assumes a single-cycle SFR bus on i_ref_clk and a core that acknowledges.
*/
`timescale 1ns/10ps
`include "uirp_regs.svh"

module uirp_port
    import uirp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_sel,
    output uirp_core_req_type o_core_req,
    input wire uirp_core_rsp_type i_core_rsp
);

    uirp_state_type state_reg, state_next;
    logic [5:0] index_reg, index_next;
    logic auto_reg, auto_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] rdata_reg, rdata_next;
    logic from_link_reg, from_link_next;
    logic start;
    logic start_write;
    logic done;
    logic [7:0] link_rdata;
    logic addr_hit, data_hit, busy;

    assign addr_hit = (i_sfr_addr == `UIRP_ADDR_PORT_OFS);
    assign data_hit = (i_sfr_addr == `UIRP_DATA_PORT_OFS);
    assign busy = (state_reg != UIRP_IDLE);

    // Port state and launch decisions
    always_comb begin
        state_next = state_reg;
        index_next = index_reg;
        auto_next = auto_reg;
        data_next = data_reg;
        from_link_next = from_link_reg;
        start = 1'b0;
        start_write = 1'b0;
        if (done) begin
            state_next = UIRP_IDLE;
            // Link flop holds the value only after this edge, so point at it
            if (state_reg == UIRP_READ) begin
                from_link_next = 1'b1;
            end
        end
        if (i_sfr_wr && addr_hit) begin
            index_next = i_sfr_wdata[`UIRP_INDEX_MSB:0];
            auto_next = i_sfr_wdata[`UIRP_AUTO_BIT];
            if (i_sfr_wdata[`UIRP_BUSY_BIT] && !busy) begin
                start = 1'b1;
                state_next = UIRP_READ;
            end
        end else if (i_sfr_wr && data_hit && !busy) begin
            data_next = i_sfr_wdata;
            from_link_next = 1'b0;
            start = 1'b1;
            start_write = 1'b1;
            state_next = UIRP_WRITE;
        end else if (i_sfr_rd && data_hit && auto_reg && !busy) begin
            start = 1'b1;
            state_next = UIRP_READ;
        end
    end

    // Read data mux, registered for the bus
    always_comb begin
        rdata_next = 8'h00;
        if (addr_hit) begin
            rdata_next = {busy, auto_reg, index_reg};
        end else if (data_hit) begin
            rdata_next = from_link_reg ? link_rdata : data_reg;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= UIRP_IDLE;
            index_reg <= `UIRP_INDEX_RST;
            auto_reg <= 1'b0;
            data_reg <= `UIRP_DATA_PORT_RST;
            from_link_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            index_reg <= index_next;
            auto_reg <= auto_next;
            data_reg <= data_next;
            from_link_reg <= from_link_next;
            rdata_reg <= rdata_next;
        end
    end

    // Index taken from the write itself so a combined write hits the new target
    uirp_core_link u_link (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .i_write(start_write),
        .i_index(index_next),
        .i_wdata(i_sfr_wdata),
        .o_core_req(o_core_req),
        .i_core_rsp(i_core_rsp),
        .o_done(done),
        .o_rdata(link_rdata)
    );

    assign o_sfr_rdata = rdata_reg;
    assign o_sfr_sel = addr_hit | data_hit; // Combinational claim of the address

endmodule // uirp_port

// >>> tb/uirp_port_bench.sv
/* Bench for uirp_port; plays the core side, assumes a free-running clock. */
`timescale 1ns/10ps
module uirp_port_bench import uirp_pkg::*;;
    logic i_ref_clk = 0, i_rst_n = 0, sw = 0, sr = 0;
    logic [7:0] sa = 8'h96, sd = 8'h00, mem [64];
    wire logic [7:0] q;
    wire logic sel;
    int err_total = 0, n_compared = 0, lat = 0;
    uirp_core_req_type req;
    uirp_core_rsp_type rsp = '0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    uirp_port i_uirp_port (.i_ref_clk, .i_rst_n, .i_sfr_addr(sa), .i_sfr_wr(sw),
        .i_sfr_rd(sr), .i_sfr_wdata(sd), .o_sfr_rdata(q), .o_sfr_sel(sel),
        .o_core_req(req), .i_core_rsp(rsp));
    // Core acks late on purpose; data scrambled between acks
    always @(posedge i_ref_clk) begin
        rsp.ack <= lat == 3;
        rsp.rdata <= lat == 3 ? mem[req.index] : ~rsp.rdata;
        lat <= req.req && !rsp.ack ? lat + 1 : 0;
        if (lat == 3 && req.write) mem[req.index] <= req.wdata;
    end
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_ref_clk);
        sa <= a;
        sd <= d;
        sw <= 1'b1;
        @(posedge i_ref_clk);
        sw <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        sa <= a;
        sr <= 1'b1;
        @(posedge i_ref_clk);
        sr <= 1'b0;
        #1;
    endtask
    task automatic chk(input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded poll, a hang ends the run
    task automatic idle;
        for (int k = 0; k < 20; k++) begin
            rd(8'h96);
            if (q[7] === 1'b0) return;
        end
        err_total++;
        give_verdict;
    endtask
    // Write, read back, index write without start, stray address, auto chain
    initial begin
        foreach (mem[k]) mem[k] = 8'h40 + 8'(k);
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(8'h96);
        chk(q, 8'h00);
        chk({7'h00, sel}, 8'h01);
        wr(8'h96, 8'h05);
        wr(8'h97, 8'h3C);
        rd(8'h96);
        chk(q, 8'h85);
        idle;
        wr(8'h96, 8'h85);
        idle;
        rd(8'h97);
        chk(q, 8'h3C);
        wr(8'h95, 8'hFF);
        chk({7'h00, sel}, 8'h00);
        wr(8'h96, 8'h06);
        rd(8'h96);
        chk(q, 8'h06);
        wr(8'h96, 8'hC6);
        idle;
        rd(8'h97);
        chk(q, 8'h46);
        rd(8'h96);
        chk(q, 8'hC6);
        idle;
        rd(8'h97);
        chk(q, 8'h46);
        // Mid-run reset with an auto read still in flight
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(8'h96);
        chk(q, 8'h00);
        rd(8'h97);
        chk(q, 8'h00);
        give_verdict;
    end
endmodule // uirp_port_bench

// >>> tb/uirp_port_sva.sv
/* Checker for uirp_port ports; assumes one clock and async low reset. */
`timescale 1ns/10ps
module uirp_port_sva
    import uirp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sfr_sel,
    input wire uirp_core_req_type o_core_req,
    input wire uirp_core_rsp_type i_core_rsp
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic rq = o_core_req.req;
    wire logic aw = i_sfr_wr && i_sfr_addr == 8'h96;
    logic auto_reg;
    // Auto flag copy, moved only by address port writes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            auto_reg <= 1'b0;
        end else if (aw) begin
            auto_reg <= i_sfr_wdata[6];
        end
    end
    sequence s_done; rq && i_core_rsp.ack ##1 !i_sfr_wr; endsequence
    property p_idx; aw && i_sfr_wdata[7] && !rq |=> rq && !o_core_req.write
        && o_core_req.index == $past(i_sfr_wdata[5:0]); endproperty
    a_idx: assert property (p_idx) else $error("launch");
    property p_nop; aw && !i_sfr_wdata[7] && !rq |=> !rq; endproperty
    a_nop: assert property (p_nop) else $error("start");
    property p_wr; i_sfr_wr && i_sfr_addr == 8'h97 && !rq |=> o_core_req.write
        && rq && o_core_req.wdata == $past(i_sfr_wdata); endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_hold; rq && !i_core_rsp.ack |=> $stable(o_core_req); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_clr; rq && i_core_rsp.ack |=> !rq; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_busy; s_done ##0 i_sfr_addr == 8'h96 |=> !o_sfr_rdata[7]; endproperty
    a_busy: assert property (p_busy) else $error("busy");
    property p_auto; i_sfr_rd && i_sfr_addr == 8'h97 && auto_reg && !rq |=> rq; endproperty
    a_auto: assert property (p_auto) else $error("auto");
    property p_sel; o_sfr_sel == (i_sfr_addr == 8'h96 || i_sfr_addr == 8'h97); endproperty
    a_sel: assert property (p_sel) else $error("select");
endmodule // uirp_port_sva
bind uirp_port uirp_port_sva i_uirp_port_sva (.*);
